// ### scg_defines.svh
// Purpose: Constants for the spreading code chip generator
// Assumes: 50 MHz system clock
// Notes:   Counts derived from times and rates live here too
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_CHIPS_PER_CODE  472
`define SCG_LAST_CHIP       9'h1D7
`define SCG_NUM_CODES       16
`define SCG_TEST_CODE       4'hF
`define SCG_SHORT_BITS      11'h155
`define SCG_LONG_BITS       11'h3FF
`define SCG_SHORT_EXTRA     121
`define SCG_LONG_EXTRA      77
`define SCG_CLK_HZ          50000000
`define SCG_BIT_RATE_DECI   95674
`define SCG_CHIP_RATE_HZ    ((`SCG_BIT_RATE_DECI * `SCG_CHIPS_PER_CODE) / 10)
`define SCG_FIFO_DEPTH      16

`endif

// ### scg_pkg.sv
// Purpose: Types for the spreading code chip generator
// Assumes: Constants come from scg_defines.svh
// Notes:   Structs carry grouped signals
package scg_pkg;

    typedef struct packed {
        logic       valid;
        logic [3:0] spreading_code_number;
    } loop_announcement_packet_t;

    typedef struct packed {
        logic       chip;
        logic [8:0] index;
        logic       period_start;
    } chip_word_t;

    typedef enum logic {ST_IDLE, ST_RUN} gen_state_t;

endpackage : scg_pkg

// ### spread_code_chip_generator.sv
// Purpose: Spreads data bits with one of sixteen stored chip codes
// Assumes: Code table loaded once before transmission starts
// Notes:   Chip timing from an internal fractional rate accumulator
// Contract
// - One code period is exactly 472 chips.
// - Sixteen code columns are held, each indexed by chip number.
// - Code number 0 to 15 selects exactly one column.
// - The code number is taken from the announcement packet field.
// - Code 15 is accepted only while test mode is on.
// - Chips go out in order 0 up to 471 in each period.
// - Telegrams of 341 or 1023 data bits are supported.
// - Data bits run at about 9567.4 bit/s, one code period per bit.
// - A data bit 1 sends the code true, a 0 sends it inverted.
`timescale 1ns/1ps
`include "scg_defines.svh"
`default_nettype none

module chip_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic             push, pop;
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready && ce;
    assign pop       = out_valid && out_ready && ce;
    always_comb begin
        wr_ptr_nxt = push ? ((wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt = pop ? ((rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1) : rd_ptr_r;
        count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule : chip_fifo

module spread_code_chip_generator
    import scg_pkg::*;
#(
    parameter int CLK_HZ    = `SCG_CLK_HZ,
    parameter int CHIP_HZ   = `SCG_CHIP_RATE_HZ,
    parameter int FIFO_DEPTH = `SCG_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // Code table load
    input  wire logic                      table_wr_en,
    input  wire logic [8:0]                table_wr_index,
    input  wire logic [15:0]               table_wr_row,
    // Code selection
    input  wire loop_announcement_packet_t announce,
    input  wire logic                      test_mode,
    output logic                           code_refused,
    // Data bits in
    input  wire logic                      bit_valid,
    output logic                           bit_ready,
    input  wire logic                      bit_data,
    // Control
    input  wire logic                      tx_enable,
    input  wire logic                      telegram_long,
    // Chip stream out
    output chip_word_t                     chip_out,
    output logic                           chip_valid,
    output logic                           telegram_last,
    output logic                           underrun
);
    localparam logic [26:0] CLK_W  = 27'(CLK_HZ);
    localparam logic [26:0] CHIP_W = 27'(CHIP_HZ);
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] code_table [`SCG_CHIPS_PER_CODE];
    always_ff @(posedge clk_sys) begin
        if (ce && table_wr_en && table_wr_index <= `SCG_LAST_CHIP) begin
            code_table[table_wr_index] <= table_wr_row;
        end
    end

    // Chip rate accumulator: one bit spans 472 chips
    logic [26:0] acc_r, acc_nxt;
    logic        tick;
    always_comb begin
        acc_nxt = acc_r + CHIP_W;
        tick    = (acc_nxt >= CLK_W);
        if (tick) begin
            acc_nxt = acc_nxt - CLK_W;
        end
    end

    // Code number capture
    logic [3:0] code_r, code_nxt, active_r, active_nxt;
    logic       refuse_nxt, refuse_r;
    always_comb begin
        code_nxt   = code_r;
        refuse_nxt = 1'b0;
        if (announce.valid) begin
            if (announce.spreading_code_number == `SCG_TEST_CODE && !test_mode) begin
                refuse_nxt = 1'b1;
            end else begin
                code_nxt = announce.spreading_code_number;
            end
        end
    end

    logic fifo_valid, fifo_data, pop;
    chip_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (bit_valid),
        .in_ready  (bit_ready),
        .in_data   (bit_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // Chip sequencer
    gen_state_t state_r, state_nxt;
    logic [8:0]  idx_r, idx_nxt;
    logic        bit_r, bit_nxt, valid_nxt, start_nxt, under_nxt, last_nxt;
    logic [10:0] tcnt_r, tcnt_nxt, tlen;
    logic        start_ok;
    chip_word_t  out_r, out_nxt;

    assign tlen     = telegram_long ? `SCG_LONG_BITS : `SCG_SHORT_BITS;
    assign start_ok = tx_enable && fifo_valid;
    always_comb begin
        state_nxt  = state_r;
        idx_nxt    = idx_r;
        bit_nxt    = bit_r;
        active_nxt = active_r;
        tcnt_nxt   = tcnt_r;
        pop        = 1'b0;
        start_nxt  = 1'b0;
        valid_nxt  = 1'b0;
        under_nxt  = 1'b0;
        last_nxt   = 1'b0;
        if (tick) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_ok) begin
                        start_nxt = 1'b1;
                    end else begin
                        under_nxt = tx_enable;
                    end
                end
                ST_RUN: begin
                    if (idx_r == `SCG_LAST_CHIP) begin
                        if (start_ok) begin
                            start_nxt = 1'b1;
                        end else begin
                            state_nxt = ST_IDLE;
                            under_nxt = tx_enable;
                        end
                    end else begin
                        idx_nxt   = idx_r + 9'h001;
                        valid_nxt = 1'b1;
                    end
                end
            endcase
        end
        if (start_nxt) begin
            pop        = 1'b1;
            state_nxt  = ST_RUN;
            idx_nxt    = '0;
            bit_nxt    = fifo_data;
            active_nxt = code_r;
            valid_nxt  = 1'b1;
            if (tcnt_r >= tlen - 11'h001) begin
                tcnt_nxt = '0;
                last_nxt = 1'b1;
            end else begin
                tcnt_nxt = tcnt_r + 11'h001;
            end
        end
        out_nxt              = out_r;
        out_nxt.period_start = start_nxt;
        if (valid_nxt) begin
            out_nxt.index = idx_nxt;
            out_nxt.chip  = code_table[idx_nxt][active_nxt] ~^ bit_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r         <= '0;
            code_r        <= '0;
            active_r      <= '0;
            refuse_r      <= 1'b0;
            state_r       <= ST_IDLE;
            idx_r         <= '0;
            bit_r         <= 1'b0;
            tcnt_r        <= '0;
            out_r         <= '0;
            chip_valid    <= 1'b0;
            underrun      <= 1'b0;
            telegram_last <= 1'b0;
        end else if (ce) begin
            acc_r         <= acc_nxt;
            code_r        <= code_nxt;
            active_r      <= active_nxt;
            refuse_r      <= refuse_nxt;
            state_r       <= state_nxt;
            idx_r         <= idx_nxt;
            bit_r         <= bit_nxt;
            tcnt_r        <= tcnt_nxt;
            out_r         <= out_nxt;
            chip_valid    <= valid_nxt;
            underrun      <= under_nxt;
            telegram_last <= last_nxt;
        end
    end

    assign chip_out     = out_r;
    assign code_refused = refuse_r;

    property p_index_range;
        out_r.index <= `SCG_LAST_CHIP;
    endproperty
    a_index_range: assert property (p_index_range) else $error("chip index past 471");
    property p_wrap;
        (ce && tick && state_r == ST_RUN && idx_r == `SCG_LAST_CHIP && start_ok)
        |=> (idx_r == 9'h000 && out_r.period_start && chip_valid);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to chip 0");
    property p_step;
        (ce && tick && state_r == ST_RUN && idx_r != `SCG_LAST_CHIP)
        |=> (chip_valid && out_r.index == $past(idx_r) + 9'h001);
    endproperty
    a_step: assert property (p_step) else $error("chip order broken");
    property p_xnor;
        chip_valid |-> (out_r.chip == (code_table[idx_r][active_r] ~^ bit_r));
    endproperty
    a_xnor: assert property (p_xnor) else $error("chip polarity wrong");
    property p_refuse;
        (ce && announce.valid && announce.spreading_code_number == `SCG_TEST_CODE && !test_mode)
        |=> (code_refused && code_r == $past(code_r));
    endproperty
    a_refuse: assert property (p_refuse) else $error("test code taken outside test");
    property p_select;
        (ce && announce.valid && announce.spreading_code_number != `SCG_TEST_CODE)
        |=> code_r == $past(announce.spreading_code_number);
    endproperty
    a_select: assert property (p_select) else $error("code number not taken");
    property p_hold_code;
        (chip_valid && !out_r.period_start) |-> $stable(active_r);
    endproperty
    a_hold_code: assert property (p_hold_code) else $error("code changed in period");
    property p_telegram;
        $rose(telegram_last) |-> ($past(tcnt_r) == $past(tlen) - 11'h001 && tcnt_r == 11'h000);
    endproperty
    a_telegram: assert property (p_telegram) else $error("telegram length wrong");
    property p_tick_gap;
        (ce && tick) |=> !(ce && tick);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("chip ticks too close");
    c_wrap:   cover property (chip_valid && out_r.period_start && $past(idx_r) == `SCG_LAST_CHIP);
    c_refuse: cover property (code_refused);
    c_test:   cover property (code_r == `SCG_TEST_CODE);
    c_last:   cover property (telegram_last);
endmodule : spread_code_chip_generator

`default_nettype wire

// ### scg_rx_model.sv
// Purpose: Receiver that despreads the chip stream back into data bits
// Assumes: Rows loaded into the generator come from code_row
// Notes:   Any index, framing or chip pattern fault bumps err_cnt
`timescale 1ns/1ps
`include "scg_defines.svh"
`default_nettype none
module scg_rx_model
    import scg_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Chip stream and code in use
    input  wire chip_word_t chip_out,
    input  wire logic       chip_valid,
    input  wire logic [3:0] code,
    output int              err_cnt
);
    bit          rx_bits[$];
    logic [8:0]  exp_idx;
    logic [3:0]  code_r;
    logic [15:0] row;
    int          agree;
    int          rx_total;
    bit          decode_ready;
    function automatic logic [15:0] code_row(input int i);
        return 16'(i * 40503) ^ 16'(i >> 3) ^ 16'h5a3c;
    endfunction : code_row
    // Sampled away from the launching edge of the registered outputs
    always @(negedge clk_sys or posedge rst) begin
        if (rst) begin
            exp_idx = 9'h000;
            err_cnt = 0;
        end else if (chip_valid === 1'b1) begin
            if (exp_idx == 9'h000) begin
                code_r = code;
                agree = 0;
            end
            if (chip_out.index !== exp_idx || chip_out.period_start !== (exp_idx == 9'h000))
                err_cnt++;
            row = code_row(int'(exp_idx));
            if (chip_out.chip === row[code_r])
                agree++;
            if (exp_idx == `SCG_LAST_CHIP) begin
                if (agree == `SCG_CHIPS_PER_CODE)
                    rx_bits.push_back(1'b1);
                else if (agree == 0)
                    rx_bits.push_back(1'b0);
                else
                    err_cnt++;
                exp_idx = 9'h000;
                rx_total++;
                decode_ready = (rx_total >= `SCG_SHORT_BITS + `SCG_SHORT_EXTRA);
            end else
                exp_idx++;
        end
    end
endmodule : scg_rx_model
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the spreading code chip generator
// Assumes: Chip rate raised to 20 MHz to keep periods short
// Notes:   Expected bits are queued as they are pushed in
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scg_pkg::*;
    logic        clk_sys, rst, table_wr_en, test_mode, code_refused, bit_valid, bit_ready;
    logic        bit_data, tx_enable, telegram_long, chip_valid, telegram_last, underrun;
    logic        saw_under, saw_last;
    logic [8:0]  table_wr_index;
    logic [15:0] table_wr_row;
    logic [3:0]  rx_code;
    logic [31:0] seed;
    loop_announcement_packet_t announce;
    chip_word_t  chip_out;
    int          failures, tests_run, rx_err, cycles;
    bit          exp_q[$];
    spread_code_chip_generator #(.CHIP_HZ(32'h0131_2d00)) u_dut (
        .clk_sys, .rst, .ce(1'b1), .table_wr_en, .table_wr_index, .table_wr_row,
        .announce, .test_mode, .code_refused, .bit_valid, .bit_ready, .bit_data,
        .tx_enable, .telegram_long, .chip_out, .chip_valid, .telegram_last, .underrun);
    scg_rx_model u_rx (.clk_sys, .rst, .chip_out, .chip_valid, .code(rx_code), .err_cnt(rx_err));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        cycles++;
        if (underrun === 1'b1) saw_under = 1'b1;
        if (telegram_last === 1'b1) saw_last = 1'b1;
        if (cycles == 100000) begin
            failures++;
            complete_run();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic refuse_exp(input logic [3:0] c, input logic tm);
        return (c == 4'hf) && !tm;
    endfunction : refuse_exp
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic announce_code(input logic [3:0] c, input logic tm);
        test_mode = tm;
        announce = '{valid: 1'b1, spreading_code_number: c};
        @(negedge clk_sys);
        announce.valid = 1'b0;
        check("code_refused", 16'(refuse_exp(c, tm)), 16'(code_refused));
        if (!refuse_exp(c, tm)) rx_code = c;
        @(negedge clk_sys);
    endtask : announce_code
    // Queue n random bits, then let them go out; fill also probes a full FIFO
    task automatic run_bits(input logic [3:0] c, input int n, input bit fill);
        logic [31:0] r;
        int          k;
        announce_code(c, 1'b1);
        r = xs();
        telegram_long = r[0];
        for (int i = 0; i < n; i++) begin
            r = xs();
            bit_data = r[9];
            bit_valid = 1'b1;
            exp_q.push_back(r[9]);
            k = 0;
            while (bit_ready !== 1'b1 && k < 50) begin
                @(negedge clk_sys);
                k++;
            end
            @(negedge clk_sys);
        end
        if (fill) begin
            check("bit_ready when full", 16'h0000, 16'(bit_ready));
            @(negedge clk_sys);
            check("bit_ready still full", 16'h0000, 16'(bit_ready));
        end
        bit_valid = 1'b0;
        saw_under = 1'b0;
        tx_enable = 1'b1;
        if (fill) announce_code(4'hf, 1'b0);
        k = 0;
        while ((u_rx.rx_bits.size() < n || saw_under !== 1'b1) && k < 1500 * n) begin
            @(negedge clk_sys);
            k++;
        end
        tx_enable = 1'b0;
        check("underrun after last bit", 16'h0001, 16'(saw_under));
        for (int i = 0; i < n; i++)
            check("despread bit", 16'(exp_q.pop_front()), 16'(u_rx.rx_bits.pop_front()));
        $display("test code %0d with %0d bits done", c, n);
    endtask : run_bits
    initial begin
        rst = 1'b1;
        seed = 32'h0000_3390;
        announce = '0;
        {test_mode, table_wr_en, bit_valid, bit_data, tx_enable, telegram_long} = 6'h00;
        {saw_under, saw_last} = 2'h0;
        table_wr_index = 9'h000;
        table_wr_row = 16'h0000;
        rx_code = 4'h0;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i <= 472; i++) begin
            table_wr_en = 1'b1;
            table_wr_index = 9'(i);
            table_wr_row = (i == 472) ? 16'hffff : u_rx.code_row(i);
            @(negedge clk_sys);
        end
        table_wr_en = 1'b0;
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 16; c++)
                announce_code(4'(c), m[0]);
        $display("test announce done");
        run_bits(4'(xs() % 15), 16, 1'b1);
        for (int c = 0; c < 16; c++)
            run_bits(4'(c), 2, 1'b0);
        check("telegram_last in short run", 16'h0000, 16'(saw_last));
        check("receiver faults", 16'h0000, 16'(rx_err));
        check("decoded bit total", 16'h0030, 16'(u_rx.rx_total));
        check("short decode window", 16'h0000, 16'(u_rx.decode_ready));
        complete_run();
    end
endmodule : tb
`default_nettype wire
